// >>> rtl/qsr_pkg.sv
// Shared constants and types for the quad-rate SRAM request scheduler
package qsr_pkg;
  typedef enum logic [1:0] {QSR_BURST2, QSR_NARROW4, QSR_WIDE4} qsr_mode_t;
  typedef enum logic {QSR_RET_BEAT0, QSR_RET_BEAT1} qsr_ret_t;
  localparam int QSR_AW = 21;
  localparam int QSR_MDW = 36;
  localparam int QSR_MBW = 4;
  localparam int QSR_TAG_DEPTH = 8;
  localparam int QSR_TAG_SLACK = 4;
  localparam int QSR_NPORTS = 2;
  localparam int QSR_PORT_WR = 0;
  localparam int QSR_PORT_RD = 1;
  localparam logic QSR_SEL_IDLE = 1'b1;
  localparam logic QSR_SEL_ACTIVE = 1'b0;
  localparam logic QSR_BE_OFF = 1'b1;
endpackage

// >>> rtl/qsr_cap_if.sv
// Captured read words passed from the echo capture to the scheduler
`timescale 1ns/1ps
`default_nettype none
interface qsr_cap_if #(
  parameter int W = 36
);
  logic stb;
  logic [W-1:0] word;
  modport src(output stb, output word);
  modport dst(input stb, input word);
endinterface
`default_nettype wire

// >>> rtl/qsr_rd_capture.sv
// Echo-clock read capture and resynchronisation onto the system clock
`timescale 1ns/1ps
`default_nettype none
module qsr_rd_capture #(
  parameter int QW = 18
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic echo_clock_pos,
  input wire logic [QW-1:0] mem_q,
  qsr_cap_if.src cap
);
  import qsr_pkg::*;

  if (QW < 1) begin : g_bad_width
    $error("qsr_rd_capture: QW must be at least 1");
  end

  logic [2:0] ck_s_r;
  logic [QW-1:0] q_s1_r;
  logic [QW-1:0] q_s2_r;
  logic [QW-1:0] lo_r;
  logic stb_r;
  logic [2*QW-1:0] word_r;
  wire ck_rise = ck_s_r[1] & ~ck_s_r[2];
  wire ck_fall = ~ck_s_r[1] & ck_s_r[2];

  // Rising half caught first, falling half completes the word
  always_ff @(posedge clk) begin
    if (srst) begin
      ck_s_r <= 3'h0;
      q_s1_r <= '0;
      q_s2_r <= '0;
      lo_r <= '0;
      stb_r <= 1'b0;
      word_r <= '0;
    end else begin
      ck_s_r <= {ck_s_r[1:0], echo_clock_pos};
      q_s1_r <= mem_q;
      q_s2_r <= q_s1_r;
      if (ck_rise) lo_r <= q_s2_r;
      stb_r <= ck_fall;
      if (ck_fall) word_r <= {q_s2_r, lo_r};
    end
  end

  assign cap.stb = stb_r;
  assign cap.word = word_r;
endmodule
`default_nettype wire

// >>> rtl/qsr_sched.sv
// Quad-rate SRAM request scheduler: host read/write ports to memory commands
`timescale 1ns/1ps
`default_nettype none
module qsr_sched #(
  parameter qsr_pkg::qsr_mode_t MODE = qsr_pkg::QSR_NARROW4,
  parameter int AW = qsr_pkg::QSR_AW,
  parameter int MDW = qsr_pkg::QSR_MDW,
  parameter int MBW = qsr_pkg::QSR_MBW,
  parameter int TAG_DEPTH = qsr_pkg::QSR_TAG_DEPTH,
  localparam int HDW = (MODE == qsr_pkg::QSR_WIDE4) ? 2 * MDW : MDW,
  localparam int HBW = (MODE == qsr_pkg::QSR_WIDE4) ? 2 * MBW : MBW
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic host_wr,
  input wire logic [AW-1:0] host_wr_addr,
  input wire logic [HDW-1:0] host_wr_data,
  input wire logic [HBW-1:0] host_wr_be_n,
  output logic host_wr_wait,
  input wire logic host_rd,
  input wire logic [AW-1:0] host_rd_addr,
  output logic host_rd_wait,
  output logic [HDW-1:0] host_rd_data,
  output logic host_rd_valid,
  output logic mem_wr_sel_n,
  output logic [AW-1:0] mem_wr_addr,
  output logic [MDW-1:0] mem_d,
  output logic [MBW-1:0] mem_bw_n,
  output logic mem_rd_sel_n,
  output logic [AW-1:0] mem_rd_addr,
  input wire logic echo_clock_pos,
  input wire logic [MDW/2-1:0] mem_q
);
  import qsr_pkg::*;

  localparam bit IS_B2 = (MODE == QSR_BURST2);
  localparam bit IS_N = (MODE == QSR_NARROW4);
  localparam bit IS_W = (MODE == QSR_WIDE4);
  localparam int TW = (TAG_DEPTH > 1) ? $clog2(TAG_DEPTH) : 1;
  localparam int CW = $clog2(TAG_DEPTH + 1);
  localparam logic [MBW-1:0] BE_OFF = {MBW{QSR_BE_OFF}};

  if (MDW < 2 || (MDW % 2) != 0 || MBW < 1 || AW < 2) begin : g_bad_width
    $error("qsr_sched: MDW must be even and at least 2, MBW at least 1, AW at least 2");
  end
  if (TAG_DEPTH <= QSR_TAG_SLACK) begin : g_bad_depth
    $error("qsr_sched: TAG_DEPTH must exceed the read slack");
  end

  function automatic logic [AW-1:0] mem_addr_of(input logic [AW-1:0] a);
    return IS_N ? (a >> 1) : a;
  endfunction

  // Per-port request control: index 0 writes, index 1 reads
  logic [1:0] in_req;
  logic [AW-1:0] in_addr [QSR_NPORTS];
  logic [1:0] req;
  logic [1:0] busy;
  logic [1:0] join_w;
  logic [1:0] fresh;
  logic [1:0] cand;
  logic [1:0] slot_ok;
  logic [1:0] start;
  logic [1:0] stall_x;
  logic [1:0] hold_v_nxt;
  logic [1:0] wait_nxt;
  logic [AW-1:0] cand_addr [QSR_NPORTS];
  logic [1:0] hold_v_r;
  logic [1:0] b1_due_r;
  logic [1:0] b1_v_r;
  logic [1:0] wait_r;
  logic [AW-1:0] hold_addr_r [QSR_NPORTS];
  logic [AW-1:0] open_addr_r [QSR_NPORTS];
  logic tag_near_full;

  assign in_req = {host_rd, host_wr};
  assign in_addr[QSR_PORT_WR] = host_wr_addr;
  assign in_addr[QSR_PORT_RD] = host_rd_addr;
  assign stall_x = {tag_near_full, 1'b0};

  for (genvar p = 0; p < QSR_NPORTS; p++) begin : g_port
    // A request seen while wait is high is not taken
    assign req[p] = in_req[p] & ~wait_r[p];
    // A four-beat burst holds its port's slot for the following cycle
    assign busy[p] = ~IS_B2 & b1_due_r[p];
    // Odd partner of an even burst opened last cycle joins it
    assign join_w[p] = req[p] & IS_N & b1_due_r[p] & ~b1_v_r[p] &
                       (in_addr[p] == open_addr_r[p] + AW'(1));
    assign fresh[p] = req[p] & ~join_w[p];
    assign cand[p] = hold_v_r[p] | fresh[p];
    assign cand_addr[p] = hold_v_r[p] ? hold_addr_r[p] : in_addr[p];
    // Shared address slot: write wins unless burst-of-two halves split it
    if (p == QSR_PORT_WR) begin : g_wr_slot
      assign slot_ok[p] = ~busy[p];
    end else begin : g_rd_slot
      assign slot_ok[p] = ~busy[p] & (IS_B2 | ~start[QSR_PORT_WR]);
    end
    assign start[p] = cand[p] & slot_ok[p];
    // Unplaced request waits in the hold register
    assign hold_v_nxt[p] = cand[p] & ~start[p];
    // Pauses reach the host as wait-request
    assign wait_nxt[p] = hold_v_nxt[p] | (IS_W & start[p]) | stall_x[p];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hold_v_r <= 2'h0;
      b1_due_r <= 2'h0;
      b1_v_r <= 2'h0;
      wait_r <= 2'h0;
      for (int i = 0; i < QSR_NPORTS; i++) begin
        hold_addr_r[i] <= '0;
        open_addr_r[i] <= '0;
      end
    end else begin
      hold_v_r <= hold_v_nxt;
      wait_r <= wait_nxt;
      for (int i = 0; i < QSR_NPORTS; i++) begin
        b1_due_r[i] <= start[i] & ~IS_B2;
        b1_v_r[i] <= start[i] & (IS_W | cand_addr[i][0]);
        hold_addr_r[i] <= cand_addr[i];
        open_addr_r[i] <= cand_addr[i];
      end
    end
  end

  // Write datapath
  logic [HDW-1:0] wr_hold_data_r;
  logic [HBW-1:0] wr_hold_be_r;
  logic [MDW-1:0] b1_data_r;
  logic [MBW-1:0] b1_be_r;
  logic wr_sel_n_r;
  logic [AW-1:0] wr_addr_r;
  logic [MDW-1:0] d_r;
  logic [MBW-1:0] bw_r;
  logic wr_sel_n_nxt;
  logic [AW-1:0] wr_addr_nxt;
  logic [MDW-1:0] d_nxt;
  logic [MBW-1:0] bw_nxt;
  logic [MDW-1:0] b1_data_nxt;
  logic [MBW-1:0] b1_be_nxt;
  wire [HDW-1:0] wr_cand_data = hold_v_r[QSR_PORT_WR] ? wr_hold_data_r : host_wr_data;
  wire [HBW-1:0] wr_cand_be = hold_v_r[QSR_PORT_WR] ? wr_hold_be_r : host_wr_be_n;
  wire [2*MDW-1:0] wr_ext = (2*MDW)'(wr_cand_data);
  wire [2*MBW-1:0] be_ext = (2*MBW)'(wr_cand_be);

  always_comb begin
    wr_sel_n_nxt = QSR_SEL_IDLE;
    wr_addr_nxt = wr_addr_r;
    d_nxt = '0;
    bw_nxt = BE_OFF;
    b1_data_nxt = b1_data_r;
    b1_be_nxt = b1_be_r;
    if (start[QSR_PORT_WR]) begin
      wr_sel_n_nxt = QSR_SEL_ACTIVE;
      wr_addr_nxt = mem_addr_of(cand_addr[QSR_PORT_WR]);
      if (IS_W) begin
        d_nxt = wr_ext[MDW-1:0];
        bw_nxt = be_ext[MBW-1:0];
        b1_data_nxt = wr_ext[2*MDW-1:MDW];
        b1_be_nxt = be_ext[2*MBW-1:MBW];
      end else if (IS_N && cand_addr[QSR_PORT_WR][0]) begin
        b1_data_nxt = wr_ext[MDW-1:0];
        b1_be_nxt = be_ext[MBW-1:0];
      end else begin
        d_nxt = wr_ext[MDW-1:0];
        bw_nxt = be_ext[MBW-1:0];
      end
    end else if (b1_due_r[QSR_PORT_WR]) begin
      if (b1_v_r[QSR_PORT_WR]) begin
        d_nxt = b1_data_r;
        bw_nxt = b1_be_r;
      end else if (join_w[QSR_PORT_WR]) begin
        d_nxt = host_wr_data[MDW-1:0];
        bw_nxt = host_wr_be_n[MBW-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_hold_data_r <= '0;
      wr_hold_be_r <= '1;
      b1_data_r <= '0;
      b1_be_r <= BE_OFF;
      wr_sel_n_r <= QSR_SEL_IDLE;
      wr_addr_r <= '0;
      d_r <= '0;
      bw_r <= BE_OFF;
    end else begin
      if (fresh[QSR_PORT_WR]) wr_hold_data_r <= host_wr_data;
      if (fresh[QSR_PORT_WR]) wr_hold_be_r <= host_wr_be_n;
      b1_data_r <= b1_data_nxt;
      b1_be_r <= b1_be_nxt;
      wr_sel_n_r <= wr_sel_n_nxt;
      wr_addr_r <= wr_addr_nxt;
      d_r <= d_nxt;
      bw_r <= bw_nxt;
    end
  end

  // Read command and return-tag tracking
  logic rd_sel_n_r;
  logic [AW-1:0] rd_addr_r;
  logic tag_k0_mem [TAG_DEPTH];
  logic tag_k1_mem [TAG_DEPTH];
  logic [TW-1:0] tag_wp_r;
  logic [TW-1:0] tag_rp_r;
  logic [CW-1:0] tag_cnt_r;
  logic tag_pop;
  wire tag_push = IS_B2 ? start[QSR_PORT_RD] : b1_due_r[QSR_PORT_RD];
  // Narrow keeps only requested words; other modes keep the whole burst
  wire tag_k0_in = ~IS_N | ~b1_v_r[QSR_PORT_RD];
  wire tag_k1_in = IS_W | (IS_N & (b1_v_r[QSR_PORT_RD] | join_w[QSR_PORT_RD]));
  wire tag_empty = (tag_cnt_r == CW'(0));
  wire [TW-1:0] tag_wp_inc = (tag_wp_r == TW'(TAG_DEPTH - 1)) ? TW'(0) : tag_wp_r + TW'(1);
  wire [TW-1:0] tag_rp_inc = (tag_rp_r == TW'(TAG_DEPTH - 1)) ? TW'(0) : tag_rp_r + TW'(1);
  assign tag_near_full = (tag_cnt_r >= CW'(TAG_DEPTH - QSR_TAG_SLACK));

  always_ff @(posedge clk) begin
    if (tag_push) begin
      tag_k0_mem[tag_wp_r] <= tag_k0_in;
      tag_k1_mem[tag_wp_r] <= tag_k1_in;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_sel_n_r <= QSR_SEL_IDLE;
      rd_addr_r <= '0;
      tag_wp_r <= '0;
      tag_rp_r <= '0;
      tag_cnt_r <= '0;
    end else begin
      rd_sel_n_r <= start[QSR_PORT_RD] ? QSR_SEL_ACTIVE : QSR_SEL_IDLE;
      if (start[QSR_PORT_RD]) rd_addr_r <= mem_addr_of(cand_addr[QSR_PORT_RD]);
      if (tag_push) tag_wp_r <= tag_wp_inc;
      if (tag_pop) tag_rp_r <= tag_rp_inc;
      tag_cnt_r <= tag_cnt_r + CW'(tag_push) - CW'(tag_pop);
    end
  end

  // Return path: words from the capture stage matched against tags
  qsr_cap_if #(.W(MDW)) cap_bus ();

  qsr_rd_capture #(.QW(MDW / 2)) u_cap (
    .clk(clk),
    .srst(srst),
    .echo_clock_pos(echo_clock_pos),
    .mem_q(mem_q),
    .cap(cap_bus.src)
  );

  qsr_ret_t ret_st_r;
  qsr_ret_t ret_st_nxt;
  logic [MDW-1:0] ret_lo_r;
  logic rd_valid_r;
  logic rd_valid_nxt;
  logic [HDW-1:0] rd_data_r;
  logic [HDW-1:0] rd_data_nxt;
  wire ret_go = cap_bus.stb & ~tag_empty;
  wire cur_k0 = tag_k0_mem[tag_rp_r];
  wire cur_k1 = tag_k1_mem[tag_rp_r];

  always_comb begin
    ret_st_nxt = ret_st_r;
    rd_valid_nxt = 1'b0;
    rd_data_nxt = rd_data_r;
    tag_pop = 1'b0;
    if (ret_go) begin
      case (ret_st_r)
        QSR_RET_BEAT0: begin
          if (IS_B2) begin
            tag_pop = 1'b1;
            rd_valid_nxt = cur_k0;
            rd_data_nxt = HDW'(cap_bus.word);
          end else begin
            ret_st_nxt = QSR_RET_BEAT1;
            rd_valid_nxt = IS_N & cur_k0;
            rd_data_nxt = HDW'(cap_bus.word);
          end
        end
        QSR_RET_BEAT1: begin
          tag_pop = 1'b1;
          ret_st_nxt = QSR_RET_BEAT0;
          if (IS_W) begin
            rd_valid_nxt = 1'b1;
            rd_data_nxt = HDW'({cap_bus.word, ret_lo_r});
          end else begin
            rd_valid_nxt = cur_k1;
            rd_data_nxt = HDW'(cap_bus.word);
          end
        end
        default: ret_st_nxt = QSR_RET_BEAT0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ret_st_r <= QSR_RET_BEAT0;
      ret_lo_r <= '0;
      rd_valid_r <= 1'b0;
      rd_data_r <= '0;
    end else begin
      ret_st_r <= ret_st_nxt;
      if (ret_go) ret_lo_r <= cap_bus.word;
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  assign host_wr_wait = wait_r[QSR_PORT_WR];
  assign host_rd_wait = wait_r[QSR_PORT_RD];
  assign host_rd_data = rd_data_r;
  assign host_rd_valid = rd_valid_r;
  assign mem_wr_sel_n = wr_sel_n_r;
  assign mem_wr_addr = wr_addr_r;
  assign mem_d = d_r;
  assign mem_bw_n = bw_r;
  assign mem_rd_sel_n = rd_sel_n_r;
  assign mem_rd_addr = rd_addr_r;
endmodule
`default_nettype wire

// >>> verification/qsr_sched_sva.sv
// Port checker for the quad-rate SRAM request scheduler
`timescale 1ns/1ps
`default_nettype none
module qsr_sched_sva #(
  parameter qsr_pkg::qsr_mode_t MODE = qsr_pkg::QSR_NARROW4,
  parameter int AW = qsr_pkg::QSR_AW,
  parameter int MBW = qsr_pkg::QSR_MBW,
  localparam int HBW = (MODE == qsr_pkg::QSR_WIDE4) ? 2 * MBW : MBW
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic host_wr,
  input wire logic [AW-1:0] host_wr_addr,
  input wire logic [HBW-1:0] host_wr_be_n,
  input wire logic host_wr_wait,
  input wire logic host_rd,
  input wire logic [AW-1:0] host_rd_addr,
  input wire logic host_rd_wait,
  input wire logic host_rd_valid,
  input wire logic mem_wr_sel_n,
  input wire logic [MBW-1:0] mem_bw_n,
  input wire logic mem_rd_sel_n,
  input wire logic [AW-1:0] mem_rd_addr,
  input wire logic echo_clock_pos
);
  import qsr_pkg::*;
  localparam bit NAR = (MODE == QSR_NARROW4);
  localparam bit B4 = (MODE != QSR_BURST2);
  wire wt = host_wr && !host_wr_wait;
  wire rt = host_rd && !host_rd_wait;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence s_iso;
    NAR && !wt ##1 wt && !host_wr_addr[0] ##1 !wt;
  endsequence
  sequence s_brk;
    NAR && !wt ##1 wt && !host_wr_addr[0] ##1 wt && host_wr_addr != $past(host_wr_addr) + 1;
  endsequence
  AST_SEL_RST: assert property (disable iff (1'b0) srst |=> mem_wr_sel_n && mem_rd_sel_n)
    else $error("memory select active after reset");
  AST_WR_TAKE: assert property (NAR && wt && !$past(wt) && !$past(host_wr_wait) |=>
    !mem_wr_sel_n || host_wr_wait)
    else $error("taken write neither issued nor held");
  AST_MASK: assert property (s_iso |=> &mem_bw_n)
    else $error("unfilled burst half not masked");
  AST_JOIN: assert property (NAR && wt && $past(wt) && !$past(wt, 2) && !$past(host_wr_addr[0])
    && host_wr_addr == $past(host_wr_addr) + 1 |=> mem_bw_n == $past(host_wr_be_n))
    else $error("second write not joined into burst");
  AST_PAUSE: assert property (s_brk |=> host_wr_wait)
    else $error("no pause after broken pair");
  AST_EXCL: assert property (B4 |-> mem_wr_sel_n || mem_rd_sel_n)
    else $error("read and write command together");
  AST_WR_GAP: assert property (B4 && !mem_wr_sel_n |=> mem_wr_sel_n)
    else $error("write commands closer than two cycles");
  AST_RD_FIRST: assert property (NAR && wt && rt && !$past(wt) && !$past(rt) |=>
    !mem_wr_sel_n && host_rd_wait ##[1:4] !mem_rd_sel_n)
    else $error("write not first or read lost");
  AST_RD_CMD: assert property (NAR && rt && !wt && !$past(rt) && !$past(wt) && mem_rd_sel_n
    && !$past(host_rd_wait) |=> !mem_rd_sel_n && mem_rd_addr == ($past(host_rd_addr) >> 1))
    else $error("read command missing or wrong address");
  AST_VALID: assert property (host_rd_valid |-> !$past(echo_clock_pos, 2))
    else $error("read valid not after echo capture");
endmodule
bind qsr_sched qsr_sched_sva #(.MODE(MODE), .AW(AW), .MBW(MBW)) u_sva (.*);
`default_nettype wire

// >>> verification/qsr_mem_model.sv
// Memory read side: answers read commands with echo clock and half words
`timescale 1ns/1ps
`default_nettype none
module qsr_mem_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic mem_rd_sel_n,
  input wire logic [qsr_pkg::QSR_AW-1:0] mem_rd_addr,
  output logic echo_clock_pos,
  output logic [qsr_pkg::QSR_MDW/2-1:0] mem_q
);
  import qsr_pkg::*;
  logic [QSR_AW-1:0] pend[$];
  logic [QSR_MDW-1:0] w;
  always @(posedge clk) begin
    if (!srst && mem_rd_sel_n === 1'b0) begin
      pend.push_back(mem_rd_addr);
    end
  end
  initial begin
    echo_clock_pos = 1'b0;
    mem_q = '0;
    forever begin
      while (pend.size() == 0) begin
        @(posedge clk);
      end
      #213;
      for (int k = 0; k < 2; k++) begin
        w = {14'h0, k[0], pend[0]};
        mem_q = w[17:0];
        echo_clock_pos = 1'b1;
        #160;
        mem_q = w[35:18];
        echo_clock_pos = 1'b0;
        #160;
      end
      mem_q = ~mem_q;
      void'(pend.pop_front());
    end
  end
endmodule
`default_nettype wire

// >>> verification/qsr_sched_test.sv
// Self-checking bench for the narrow burst-of-four scheduler
`timescale 1ns/1ps
`default_nettype none
module qsr_sched_test;
  import qsr_pkg::*;
  logic clk, srst, host_wr, host_rd, host_wr_wait, host_rd_wait, host_rd_valid;
  logic mem_wr_sel_n, mem_rd_sel_n, echo_clock_pos;
  logic [QSR_AW-1:0] host_wr_addr, host_rd_addr, mem_wr_addr, mem_rd_addr;
  logic [QSR_MDW-1:0] host_wr_data, host_rd_data, mem_d;
  logic [QSR_MBW-1:0] host_wr_be_n, mem_bw_n;
  logic [QSR_MDW/2-1:0] mem_q;
  logic [100:0] wq[$];
  logic [QSR_MDW-1:0] rq[$];
  logic [60:0] wb0;
  logic wph = 1'b0;
  int fail_count, n_tests, waits, rcmds;
  qsr_sched #(.MODE(QSR_NARROW4)) DUT (.clk(clk), .srst(srst),
    .host_wr(host_wr), .host_wr_addr(host_wr_addr), .host_wr_data(host_wr_data),
    .host_wr_be_n(host_wr_be_n), .host_wr_wait(host_wr_wait), .host_rd(host_rd),
    .host_rd_addr(host_rd_addr), .host_rd_wait(host_rd_wait), .host_rd_data(host_rd_data),
    .host_rd_valid(host_rd_valid), .mem_wr_sel_n(mem_wr_sel_n), .mem_wr_addr(mem_wr_addr),
    .mem_d(mem_d), .mem_bw_n(mem_bw_n), .mem_rd_sel_n(mem_rd_sel_n),
    .mem_rd_addr(mem_rd_addr), .echo_clock_pos(echo_clock_pos), .mem_q(mem_q));
  qsr_mem_model u_mem (.clk(clk), .srst(srst), .mem_rd_sel_n(mem_rd_sel_n),
    .mem_rd_addr(mem_rd_addr), .echo_clock_pos(echo_clock_pos), .mem_q(mem_q));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Records each write burst and each returned read word
  always @(posedge clk) begin
    if (wph) wq.push_back({wb0, mem_d, mem_bw_n});
    wph = (mem_wr_sel_n === 1'b0);
    wb0 = {mem_wr_addr, mem_d, mem_bw_n};
    if (mem_rd_sel_n === 1'b0) rcmds++;
    if (host_rd_valid === 1'b1) rq.push_back(host_rd_data);
  end
  function automatic logic [35:0] wd(input logic [20:0] a);
    return {a[14:0], a};
  endfunction
  function automatic logic [3:0] be(input logic [20:0] a);
    return a[3:0] ^ 4'ha;
  endfunction
  function automatic logic [35:0] mw(input logic [20:0] a, input logic k);
    return {14'h0, k, a};
  endfunction
  task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic clr();
    wq.delete();
    rq.delete();
    waits = 0;
    rcmds = 0;
  endtask
  task automatic req(input bit w, input logic [20:0] a);
    @(negedge clk);
    if (w) begin
      host_wr = 1'b1;
      host_wr_addr = a;
      host_wr_data = wd(a);
      host_wr_be_n = be(a);
    end else begin
      host_rd = 1'b1;
      host_rd_addr = a;
    end
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      if ((w ? host_wr_wait : host_rd_wait) === 1'b0) break;
      waits++;
    end
  endtask
  task automatic idle(input int n);
    @(negedge clk);
    host_wr = 1'b0;
    host_rd = 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_rd(input int n);
    for (int i = 0; i < 200 && rq.size() < n; i++) @(posedge clk);
    repeat (30) @(posedge clk);
    chk("read words", rq.size(), n);
  endtask
  task automatic t_iso();
    clr();
    req(1, 21'h4);
    idle(6);
    chk("write waits", waits, 0);
    chk("isolated write", wq[0], {21'h2, wd(21'h4), be(21'h4), 36'h0, 4'hf});
  endtask
  task automatic t_stream();
    clr();
    for (int i = 8; i < 12; i++) req(1, i);
    idle(6);
    chk("stream waits", waits, 0);
    chk("burst count", wq.size(), 2);
    chk("burst a", wq[0], {21'h4, wd(21'h8), be(21'h8), wd(21'h9), be(21'h9)});
    chk("burst b", wq[1], {21'h5, wd(21'ha), be(21'ha), wd(21'hb), be(21'hb)});
  endtask
  task automatic t_pause();
    clr();
    req(1, 21'h10);
    req(1, 21'h14);
    req(1, 21'h15);
    idle(6);
    chk("pair waits", waits, 1);
    chk("single", wq[0], {21'h8, wd(21'h10), be(21'h10), 36'h0, 4'hf});
    chk("pair", wq[1], {21'ha, wd(21'h14), be(21'h14), wd(21'h15), be(21'h15)});
  endtask
  task automatic t_rd(input logic [20:0] a);
    clr();
    req(0, a);
    idle(0);
    wait_rd(1);
    chk("read commands", rcmds, 1);
    chk("read data", rq[0], mw(a >> 1, a[0]));
  endtask
  task automatic t_rd_pair();
    clr();
    req(0, 21'hc);
    req(0, 21'hd);
    idle(0);
    wait_rd(2);
    chk("pair commands", rcmds, 1);
    chk("pair words", {rq[0], rq[1]}, {mw(21'h6, 1'b0), mw(21'h6, 1'b1)});
  endtask
  task automatic t_rd_pause();
    clr();
    req(0, 21'h18);
    req(0, 21'h1c);
    req(0, 21'h1d);
    idle(0);
    wait_rd(3);
    chk("read waits", waits, 1);
    chk("read commands", rcmds, 2);
    chk("read words", {rq[0], rq[1], rq[2]},
      {mw(21'hc, 1'b0), mw(21'he, 1'b0), mw(21'he, 1'b1)});
  endtask
  task automatic t_both();
    clr();
    @(negedge clk);
    host_wr = 1'b1;
    host_wr_addr = 21'h28;
    host_wr_data = wd(21'h28);
    host_wr_be_n = be(21'h28);
    host_rd = 1'b1;
    host_rd_addr = 21'h2c;
    chk("both waits", {host_wr_wait, host_rd_wait}, 2'b00);
    idle(0);
    chk("write first", {mem_wr_sel_n, mem_rd_sel_n, host_rd_wait}, 3'b011);
    @(negedge clk);
    chk("read next", {mem_wr_sel_n, mem_rd_sel_n}, 2'b10);
    wait_rd(1);
    chk("deferred read", rq[0], mw(21'h16, 1'b0));
  endtask
  initial begin
    #400000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    fail_count = 0;
    n_tests = 0;
    srst = 1'b1;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wr_addr = '0;
    host_rd_addr = '0;
    host_wr_data = '0;
    host_wr_be_n = '1;
    repeat (5) @(negedge clk);
    chk("reset outputs", {mem_wr_sel_n, mem_rd_sel_n, mem_bw_n, host_wr_wait}, 7'h7e);
    repeat (5) @(negedge clk);
    srst = 1'b0;
    t_iso();
    t_stream();
    t_pause();
    t_rd(21'h6);
    t_rd(21'h7);
    t_rd_pair();
    t_rd_pause();
    t_both();
    report_and_stop();
  end
endmodule
`default_nettype wire
